// [rtl/osgc_pkg.sv]
// Purpose: Shared constants and carrier types for the output stage gain control block.
// Assumes: Registers are 9 bits wide and sit in the low bits of a 32-bit APB word.
// Notes:   Byte address of a register is four times its index.
package osgc_pkg;

  // Register indices (byte address = index * 4)
  localparam logic [5:0] OSGC_IDX_POWER_MGMT_ONE      = 6'h01;
  localparam logic [5:0] OSGC_IDX_ADDITIONAL_CONTROL  = 6'h07;
  localparam logic [5:0] OSGC_IDX_BEEP_CONTROL        = 6'h2b;
  localparam logic [5:0] OSGC_IDX_OUTPUT_CONTROL      = 6'h31;
  localparam logic [5:0] OSGC_IDX_HEADPHONE_LEFT_VOL  = 6'h34;
  localparam logic [5:0] OSGC_IDX_HEADPHONE_RIGHT_VOL = 6'h35;
  localparam logic [5:0] OSGC_IDX_SPEAKER_LEFT_VOL    = 6'h36;
  localparam logic [5:0] OSGC_IDX_SPEAKER_RIGHT_VOL   = 6'h37;
  localparam logic [5:0] OSGC_IDX_THIRD_OUTPUT_MIXER  = 6'h38;
  localparam logic [5:0] OSGC_IDX_FOURTH_OUTPUT_MIXER = 6'h39;
  localparam logic [5:0] OSGC_IDX_GAIN_STATUS         = 6'h3a;

  // Volume register fields
  localparam int unsigned OSGC_VOL_UPDATE_BIT = 8;
  localparam int unsigned OSGC_VOL_ZC_BIT     = 7;
  localparam int unsigned OSGC_VOL_MUTE_BIT   = 6;
  localparam int unsigned OSGC_VOL_LSB        = 0;
  localparam int unsigned OSGC_VOL_W          = 6;
  localparam logic [7:0]  OSGC_VOL_RESET      = 8'h39;

  // Control bit positions
  localparam int unsigned OSGC_LEVEL_SHIFT_BUF_BIT = 8;
  localparam int unsigned OSGC_SLOW_CLOCK_BIT      = 0;
  localparam int unsigned OSGC_SPEAKER_BOOST_BIT   = 2;
  localparam int unsigned OSGC_INV_MAIN_MUTE_BIT   = 5;
  localparam int unsigned OSGC_RIGHT_INVERT_BIT    = 4;
  localparam int unsigned OSGC_BEEP_GAIN_LSB       = 1;
  localparam int unsigned OSGC_BEEP_ENABLE_BIT     = 0;
  localparam int unsigned OSGC_THIRD_MUTE_BIT      = 6;
  localparam int unsigned OSGC_FOURTH_MUTE_BIT     = 6;
  localparam int unsigned OSGC_FOURTH_ATTN_BIT     = 5;

  // Reset values and writable masks
  localparam logic [8:0] OSGC_CTRL_RESET   = 9'h000;
  localparam logic [8:0] OSGC_THIRD_RESET  = 9'h001;
  localparam logic [8:0] OSGC_FOURTH_RESET = 9'h001;
  localparam logic [8:0] OSGC_THIRD_MASK   = 9'h04f;
  localparam logic [8:0] OSGC_FOURTH_MASK  = 9'h0ff;

  // Zero-cross timeout: 2^21 system clock periods
  localparam int unsigned OSGC_ZC_TIMEOUT_EXP    = 21;
  localparam int unsigned OSGC_ZC_TIMEOUT_CYCLES = 2 ** OSGC_ZC_TIMEOUT_EXP;

  // Number of volume PGAs: 0 hp left, 1 hp right, 2 spk left, 3 spk right
  localparam int unsigned OSGC_NUM_PGA = 4;

  typedef enum logic [0:0] {
    CM_IDLE  = 1'b0,
    CM_ARMED = 1'b1
  } osgc_commit_e;

  // One output PGA as seen by the analogue stage
  typedef struct packed {
    logic       mute;
    logic [5:0] volume;
  } osgc_pga_s;

  // Speaker stage, inverter and beep mixer controls
  typedef struct packed {
    logic       speaker_boost_select;
    logic       level_shift_buffer_en;
    logic       right_speaker_invert;
    logic       inverter_main_input_mute;
    logic       beep_enable;
    logic [2:0] beep_gain;
  } osgc_spk_s;

  // Third and fourth output mixers and stages
  typedef struct packed {
    logic third_output_mute;
    logic fourth_mix_to_third;
    logic left_bypass_to_third;
    logic left_mixer_to_third;
    logic left_dac_to_third;
    logic fourth_output_mute;
    logic fourth_output_attenuate;
    logic third_mix_to_fourth;
    logic left_mixer_to_fourth;
    logic left_dac_to_fourth;
    logic right_bypass_to_fourth;
    logic right_mixer_to_fourth;
    logic right_dac_to_fourth;
  } osgc_aux_s;

endpackage : osgc_pkg

// [rtl/osgc_gain_commit.sv]
// Purpose: Decides when one pending PGA gain is applied, with zero-cross timeout.
// Assumes: zc_event is a one-cycle pulse already synchronised to mclk.
// Notes:   commit is combinational so an immediate update lands on the write edge.
module osgc_gain_commit #(
  parameter int unsigned TIMEOUT_CYCLES = osgc_pkg::OSGC_ZC_TIMEOUT_CYCLES,
  parameter int unsigned CW             = $clog2(TIMEOUT_CYCLES) + 1
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Control
  input  wire logic trigger,
  input  wire logic zc_enable,
  input  wire logic zc_event,
  input  wire logic slow_enable,
  // Result
  output logic      commit,
  output logic      armed
);
  import osgc_pkg::*;

  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYCLES - 1);

  osgc_commit_e  state_q;
  osgc_commit_e  state_d;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic          timeout;

  // Timeout only advances while the slow clock is enabled
  assign timeout = slow_enable & (count_q == LAST);
  assign armed   = (state_q == CM_ARMED);

  // Next state; a new trigger with zero-cross on restarts the wait with the new value
  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    commit  = 1'b0;
    case (state_q)
      CM_IDLE:
      begin
        if (trigger && zc_enable)
        begin
          state_d = CM_ARMED;
          count_d = '0;
        end
        else if (trigger)
        begin
          commit = 1'b1;
        end
      end
      CM_ARMED:
      begin
        if (trigger && zc_enable)
        begin
          count_d = '0;
        end
        else if (trigger || !zc_enable || zc_event || timeout)
        begin
          commit  = 1'b1;
          state_d = CM_IDLE;
          count_d = '0;
        end
        else if (slow_enable)
        begin
          count_d = count_q + 1'b1;
        end
      end
      default:
      begin
        state_d = CM_IDLE;
        count_d = '0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= CM_IDLE;
      count_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

endmodule : osgc_gain_commit

// [rtl/osgc_top.sv]
// Purpose: Register bank and gain sequencing for the analogue output stages.
// Assumes: APB slave, zero wait states; zero-cross detector inputs are asynchronous.
// Notes:   Volume fields read back the pending value; applied gains leave on pga_drive.
// Function
// - Headphone volumes wait pending until a headphone update bit is written as one.
// - Speaker volumes wait pending until a speaker update bit is written as one.
// - Zero-cross enabled gains change at a crossing, otherwise at once.
// - Volumes are six-bit codes, 1dB steps, reset to the 0dB code.
// - Speaker mute silences the output while its DC level stays driven.
// - Speaker boost picks inverting unity or non-inverting 1.5x level-shifted stage.
// - Right-speaker invert bit routes that output through the inverter.
// - Beep enable mixes right auxiliary input into the inverter, three-bit gain.
// - Inverter-mixer mute silences the main input of the inverter mixer.
// - With slow clock on, a waiting gain is forced after 2^21 clocks.
// - Slow clock enable also drives the jack-insert debounce circuit.
// - Fourth-output attenuate bit cuts that output by 6dB.
// - Third/fourth mute makes the stage drive the midrail reference.
// - Third mixer sums its four selected sources, left DAC on at reset.
// - Fourth mixer sums third mixer, left mixer, left DAC, right bypass, right mixer.
// - Speaker outputs carry left/right mixer results scaled by their own controls.
// - Fourth mixer also takes the right DAC, selected at reset.
module osgc_top
  import osgc_pkg::*;
#(
  parameter int unsigned ZC_TIMEOUT_CYCLES = osgc_pkg::OSGC_ZC_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic                                      mclk,
  input  wire logic                                      nrst,
  // APB slave
  input  wire logic                                      psel,
  input  wire logic                                      penable,
  input  wire logic                                      pwrite,
  input  wire logic [7:0]                                paddr,
  input  wire logic [31:0]                               pwdata,
  output logic [31:0]                                    prdata,
  output logic                                           pready,
  output logic                                           pslverr,
  // Zero-cross detectors, one per PGA, asynchronous
  input  wire logic [osgc_pkg::OSGC_NUM_PGA-1:0]         zero_cross_in,
  // Analogue stage controls
  output osgc_pkg::osgc_pga_s [osgc_pkg::OSGC_NUM_PGA-1:0] pga_drive,
  output osgc_pkg::osgc_spk_s                            spk_drive,
  output osgc_pkg::osgc_aux_s                            aux_drive,
  output logic [8:0]                                     power_mgmt_one_bits,
  output logic [8:0]                                     output_control_bits,
  output logic                                           jack_debounce_enable
);
  import osgc_pkg::*;

  localparam int unsigned NP = OSGC_NUM_PGA;

  // Bus phase decode
  wire       apb_setup  = psel & ~penable;
  wire       apb_access = psel & penable;
  wire       apb_wr     = apb_access & pwrite;
  wire [5:0] reg_index  = paddr[7:2];

  // Register selects
  wire sel_pm1   = (reg_index == OSGC_IDX_POWER_MGMT_ONE);
  wire sel_addc  = (reg_index == OSGC_IDX_ADDITIONAL_CONTROL);
  wire sel_beep  = (reg_index == OSGC_IDX_BEEP_CONTROL);
  wire sel_outc  = (reg_index == OSGC_IDX_OUTPUT_CONTROL);
  wire sel_hpl   = (reg_index == OSGC_IDX_HEADPHONE_LEFT_VOL);
  wire sel_hpr   = (reg_index == OSGC_IDX_HEADPHONE_RIGHT_VOL);
  wire sel_spl   = (reg_index == OSGC_IDX_SPEAKER_LEFT_VOL);
  wire sel_spr   = (reg_index == OSGC_IDX_SPEAKER_RIGHT_VOL);
  wire sel_third = (reg_index == OSGC_IDX_THIRD_OUTPUT_MIXER);
  wire sel_four  = (reg_index == OSGC_IDX_FOURTH_OUTPUT_MIXER);
  wire sel_stat  = (reg_index == OSGC_IDX_GAIN_STATUS);

  wire [NP-1:0] sel_vol = {sel_spr, sel_spl, sel_hpr, sel_hpl};
  wire          mapped  = sel_pm1 | sel_addc | sel_beep | sel_outc | (|sel_vol)
                          | sel_third | sel_four | sel_stat;

  // Unmapped offsets answer with an error and change nothing
  assign pready  = 1'b1;
  assign pslverr = apb_access & ~mapped;

  // Update strobes: bit 8 written as one, self-clearing, never stored
  wire hp_update  = apb_wr & (sel_hpl | sel_hpr) & pwdata[OSGC_VOL_UPDATE_BIT];
  wire spk_update = apb_wr & (sel_spl | sel_spr) & pwdata[OSGC_VOL_UPDATE_BIT];
  wire [NP-1:0] vol_trigger = {spk_update, spk_update, hp_update, hp_update};

  // Control registers
  logic [8:0] pm1_q;
  logic [8:0] addc_q;
  logic [8:0] beep_q;
  logic [8:0] outc_q;
  logic [8:0] third_q;
  logic [8:0] four_q;
  logic [31:0] prdata_q;

  // Per-PGA state
  logic [7:0]    vol_q     [NP];
  logic [7:0]    vol_d     [NP];
  logic [5:0]    applied_q [NP];
  logic [NP-1:0] pga_armed;
  logic [NP-1:0] pga_commit;
  logic [NP-1:0] zc_meta_q;
  logic [NP-1:0] zc_sync_q;
  logic [NP-1:0] zc_prev_q;
  wire  [NP-1:0] zc_event = zc_sync_q & ~zc_prev_q;

  wire slow_clock_enable = addc_q[OSGC_SLOW_CLOCK_BIT];

  // Plain control registers; masks keep reserved bits of the third and fourth mixer registers at zero
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pm1_q   <= OSGC_CTRL_RESET;
      addc_q  <= OSGC_CTRL_RESET;
      beep_q  <= OSGC_CTRL_RESET;
      outc_q  <= OSGC_CTRL_RESET;
      third_q <= OSGC_THIRD_RESET;
      four_q  <= OSGC_FOURTH_RESET;
    end
    else if (apb_wr)
    begin
      if (sel_pm1)
        pm1_q <= pwdata[8:0];
      if (sel_addc)
        addc_q <= pwdata[8:0];
      if (sel_beep)
        beep_q <= pwdata[8:0];
      if (sel_outc)
        outc_q <= pwdata[8:0];
      if (sel_third)
        third_q <= pwdata[8:0] & OSGC_THIRD_MASK;
      if (sel_four)
        four_q <= pwdata[8:0] & OSGC_FOURTH_MASK;
    end
  end

  // One volume PGA per entry: pending field, synchroniser, commit, applied gain
  generate
    for (genvar g = 0; g < NP; g++)
    begin : g_pga
      // Pending value follows the write at once; the gain itself does not
      assign vol_d[g] = (apb_wr && sel_vol[g]) ? pwdata[7:0] : vol_q[g];

      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          vol_q[g] <= OSGC_VOL_RESET;
        end
        else
        begin
          vol_q[g] <= vol_d[g];
        end
      end

      // Detector is analogue and asynchronous: two flops before any logic
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          zc_meta_q[g] <= 1'b0;
          zc_sync_q[g] <= 1'b0;
          zc_prev_q[g] <= 1'b0;
        end
        else
        begin
          zc_meta_q[g] <= zero_cross_in[g];
          zc_sync_q[g] <= zc_meta_q[g];
          zc_prev_q[g] <= zc_sync_q[g];
        end
      end

      osgc_gain_commit #(
        .TIMEOUT_CYCLES (ZC_TIMEOUT_CYCLES)
      ) u_commit (
        .mclk        (mclk),
        .nrst        (nrst),
        .trigger     (vol_trigger[g]),
        .zc_enable   (vol_d[g][OSGC_VOL_ZC_BIT]),
        .zc_event    (zc_event[g]),
        .slow_enable (slow_clock_enable),
        .commit      (pga_commit[g]),
        .armed       (pga_armed[g])
      );

      // Commit takes the newest pending value, so a same-cycle write is not lost
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          applied_q[g] <= OSGC_VOL_RESET[5:0];
        end
        else if (pga_commit[g])
        begin
          applied_q[g] <= vol_d[g][5:0];
        end
      end

      // Mute acts at once; only the volume waits for the update strobe
      assign pga_drive[g].mute   = vol_q[g][OSGC_VOL_MUTE_BIT];
      assign pga_drive[g].volume = applied_q[g];
    end
  endgenerate

  // Read data selection; bit 8 of volume words always reads zero
  wire [8:0] rd_vol =
    sel_hpl ? {1'b0, vol_q[0]} :
    sel_hpr ? {1'b0, vol_q[1]} :
    sel_spl ? {1'b0, vol_q[2]} :
    sel_spr ? {1'b0, vol_q[3]} : 9'h000;

  wire [8:0] rd_ctrl =
    sel_pm1   ? pm1_q   :
    sel_addc  ? addc_q  :
    sel_beep  ? beep_q  :
    sel_outc  ? outc_q  :
    sel_third ? third_q :
    sel_four  ? four_q  :
    sel_stat  ? {5'h00, pga_armed} : 9'h000;

  wire [31:0] rd_word = {23'h000000, rd_vol | rd_ctrl};

  // Capture read data in setup so the zero-wait access phase sees a flop
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata_q <= 32'h00000000;
    end
    else if (apb_setup && !pwrite)
    begin
      prdata_q <= rd_word;
    end
  end

  assign prdata = prdata_q;

  // Speaker stage; boost changes are not guarded, software keeps it quiet
  assign spk_drive.speaker_boost_select     = outc_q[OSGC_SPEAKER_BOOST_BIT];
  assign spk_drive.level_shift_buffer_en    = pm1_q[OSGC_LEVEL_SHIFT_BUF_BIT];
  assign spk_drive.right_speaker_invert     = beep_q[OSGC_RIGHT_INVERT_BIT];
  assign spk_drive.inverter_main_input_mute = beep_q[OSGC_INV_MAIN_MUTE_BIT];
  assign spk_drive.beep_enable              = beep_q[OSGC_BEEP_ENABLE_BIT];
  assign spk_drive.beep_gain                = beep_q[OSGC_BEEP_GAIN_LSB +: 3];

  // Third output stage and its mixer selects
  assign aux_drive.third_output_mute    = third_q[OSGC_THIRD_MUTE_BIT];
  assign aux_drive.fourth_mix_to_third  = third_q[3];
  assign aux_drive.left_bypass_to_third = third_q[2];
  assign aux_drive.left_mixer_to_third  = third_q[1];
  assign aux_drive.left_dac_to_third    = third_q[0];

  // Fourth output stage, attenuator and its mixer selects
  assign aux_drive.fourth_output_mute      = four_q[OSGC_FOURTH_MUTE_BIT];
  assign aux_drive.fourth_output_attenuate = four_q[OSGC_FOURTH_ATTN_BIT];
  assign aux_drive.third_mix_to_fourth     = four_q[7];
  assign aux_drive.left_mixer_to_fourth    = four_q[4];
  assign aux_drive.left_dac_to_fourth      = four_q[3];
  assign aux_drive.right_bypass_to_fourth  = four_q[2];
  assign aux_drive.right_mixer_to_fourth   = four_q[1];
  assign aux_drive.right_dac_to_fourth     = four_q[0];

  // Whole registers for stages handled elsewhere in the chip
  assign power_mgmt_one_bits = pm1_q;
  assign output_control_bits = outc_q;

  // Shared slow clock gate: turning it off also stops jack debounce
  assign jack_debounce_enable = slow_clock_enable;

endmodule : osgc_top

// [bench/osgc_properties.sv]
// Purpose: Concurrent checks on the register and gain ports of the output stage block.
// Assumes: One clock domain; an APB write lands at the edge that ends its access phase.
// Notes:   Attached by bind below; sees only top-level ports.
module osgc_checker
  import osgc_pkg::*;
#(
  parameter int unsigned ZC_TIMEOUT_CYCLES = 16
) (
  // Clock and reset
  input wire logic            mclk,
  input wire logic            nrst,
  // APB slave side
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic            pslverr,
  // Analogue controls
  input osgc_pga_s [3:0]      pga_drive,
  input osgc_spk_s            spk_drive,
  input osgc_aux_s            aux_drive,
  input wire logic            jack_debounce_enable
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // Register decode; status index 0x3a is mapped but read-only
  wire logic [5:0] idx    = paddr[7:2];
  wire logic       wr_any = psel && penable && pwrite;
  wire logic       mapped = idx inside {6'h01, 6'h07, 6'h2b, 6'h31, [6'h34:6'h3a]};

  // Access phase of a write to one register
  sequence wr_at(logic [5:0] i);
    wr_any && (idx == i);
  endsequence

  AST_UNMAPPED_ERR:
    assert property (psel && penable |-> pslverr == !mapped)
    else $error("slave error does not match address decode");
  AST_HP_IMMEDIATE:
    assert property (wr_at(6'h35) ##0 (pwdata[8] && !pwdata[7])
                     |=> pga_drive[1].volume == $past(pwdata[5:0]))
    else $error("headphone right gain not applied at once");
  AST_SPK_IMMEDIATE:
    assert property (wr_at(6'h37) ##0 (pwdata[8] && !pwdata[7])
                     |=> pga_drive[3].volume == $past(pwdata[5:0]))
    else $error("speaker right gain not applied at once");
  AST_SPK_MUTE:
    assert property (wr_at(6'h36) |=> pga_drive[2].mute == $past(pwdata[6]))
    else $error("speaker left mute not taken");
  AST_MUTE_HOLDS:
    assert property (!wr_any |=> $stable(pga_drive[2].mute))
    else $error("speaker left mute moved without a write");
  AST_BEEP:
    assert property (wr_at(6'h2b) |=> spk_drive.beep_gain == $past(pwdata[3:1])
                     && spk_drive.beep_enable == $past(pwdata[0]))
    else $error("beep controls wrong");
  AST_INVERT:
    assert property (wr_at(6'h2b) |=> spk_drive.right_speaker_invert == $past(pwdata[4])
                     && spk_drive.inverter_main_input_mute == $past(pwdata[5]))
    else $error("inverter controls wrong");
  AST_BOOST:
    assert property (wr_at(6'h31) |=> spk_drive.speaker_boost_select == $past(pwdata[2]))
    else $error("speaker boost select wrong");
  AST_DEBOUNCE:
    assert property (wr_at(6'h07) |=> jack_debounce_enable == $past(pwdata[0]))
    else $error("debounce enable does not follow slow clock bit");
  AST_THIRD:
    assert property (wr_at(6'h38) |=> aux_drive.third_output_mute == $past(pwdata[6])
                     && aux_drive.left_dac_to_third == $past(pwdata[0]))
    else $error("third mixer controls wrong");
  AST_FOURTH:
    assert property (wr_at(6'h39) |=> aux_drive.fourth_output_attenuate == $past(pwdata[5])
                     && aux_drive.right_dac_to_fourth == $past(pwdata[0]))
    else $error("fourth mixer controls wrong");
endmodule : osgc_checker

bind osgc_top osgc_checker #(.ZC_TIMEOUT_CYCLES(ZC_TIMEOUT_CYCLES)) i_osgc_checker (
  .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .pga_drive(pga_drive),
  .spk_drive(spk_drive), .aux_drive(aux_drive), .jack_debounce_enable(jack_debounce_enable)
);

// [bench/tb.sv]
// Purpose: Self-checking bench for the output stage gain control register bank.
// Assumes: Zero-cross timeout shortened to ZC cycles; one idle cycle between transfers.
// Notes:   Expectations come from the register map, never from design outputs.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import osgc_pkg::*;

  localparam int unsigned ZC = 16;

  // Clock, reset and APB
  logic            mclk;
  logic            nrst;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [7:0]      paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  // Analogue side
  logic [3:0]      zero_cross_in;
  osgc_pga_s [3:0] pga_drive;
  osgc_spk_s       spk_drive;
  osgc_aux_s       aux_drive;
  logic [8:0]      power_mgmt_one_bits;
  logic [8:0]      output_control_bits;
  logic            jack_debounce_enable;
  // Bookkeeping and register table
  logic            last_err;
  int              err_total;
  int              checks;
  logic [7:0]      tab_a [8];
  logic [8:0]      tab_r [8];
  logic [8:0]      tab_m [8];

  osgc_top #(.ZC_TIMEOUT_CYCLES(ZC)) i_osgc_top (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zero_cross_in(zero_cross_in), .pga_drive(pga_drive), .spk_drive(spk_drive),
    .aux_drive(aux_drive), .power_mgmt_one_bits(power_mgmt_one_bits),
    .output_control_bits(output_control_bits), .jack_debounce_enable(jack_debounce_enable)
  );

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // Print counts and verdict, then stop
  task automatic wrap_up();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // Compare one observed value against its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the wait for pready is bounded so a stuck slave ends the run
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      err_total++;
      wrap_up();
    end
    q = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [8:0] d);
    logic [31:0] q;
    apb(1'b1, a, {23'h0, d}, q);
  endtask : wr

  // Read and compare data and the slave error flag
  task automatic rd(input logic [7:0] a, input logic [8:0] e, input logic ue);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, {23'h0, e});
    chk({31'h0, last_err}, {31'h0, ue});
  endtask : rd

  initial
  begin
    mclk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    zero_cross_in = 4'h0;
    last_err = 1'b0;
    err_total = 0;
    checks = 0;
    tab_a = '{8'h04, 8'h1c, 8'hac, 8'hc4, 8'he0, 8'he4, 8'hd4, 8'hd8};
    tab_r = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h001, 9'h001, 9'h039, 9'h039};
    tab_m = '{9'h1ff, 9'h1ff, 9'h1ff, 9'h1ff, 9'h04f, 9'h0ff, 9'h0ff, 9'h0ff};
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 8; i++)
      rd(tab_a[i], tab_r[i], 1'b0);
    chk(32'(pga_drive), {4'h0, {4{7'h39}}});
    $display("test reset done");
    // Headphone pair: left waits until the right write carries the update bit
    wr(8'hd0, 9'h000);
    chk(32'(pga_drive[0]), 32'h39);
    wr(8'hd4, 9'h13f);
    chk(32'(pga_drive[1:0]), 32'h1f80);
    rd(8'hd4, 9'h03f, 1'b0);
    $display("test headphone done");
    // Speaker pair: left armed for a crossing, right immediate, mute not deferred
    wr(8'hd8, 9'h0c5);
    chk(32'(pga_drive[2]), 32'h79);
    wr(8'hdc, 9'h13f);
    chk(32'(pga_drive[3:2]), {18'h0, 7'h3f, 7'h79});
    rd(8'he8, 9'h004, 1'b0);
    zero_cross_in <= 4'h4;
    repeat (2) @(posedge mclk);
    chk(32'(pga_drive[2]), 32'h79);
    repeat (2) @(posedge mclk);
    chk(32'(pga_drive[2]), 32'h45);
    zero_cross_in <= 4'h0;
    rd(8'he8, 9'h000, 1'b0);
    $display("test zero cross done");
    // Timeout counts only while the slow clock is enabled
    wr(8'hd8, 9'h187);
    repeat (3 * ZC) @(posedge mclk);
    chk(32'(pga_drive[2]), 32'h05);
    wr(8'h1c, 9'h001);
    chk(32'(jack_debounce_enable), 32'h1);
    repeat (ZC - 3) @(posedge mclk);
    chk(32'(pga_drive[2]), 32'h05);
    repeat (6) @(posedge mclk);
    chk(32'(pga_drive[2]), 32'h07);
    rd(8'he8, 9'h000, 1'b0);
    $display("test timeout done");
    // Control registers all ones, then all zeros
    for (int p = 1; p >= 0; p--)
    begin
      for (int i = 0; i < 6; i++)
        wr(tab_a[i], p ? 9'h1ff : 9'h000);
      for (int i = 0; i < 6; i++)
        rd(tab_a[i], p ? tab_m[i] : 9'h000, 1'b0);
      chk(32'(spk_drive), p ? 32'hff : 32'h0);
      chk(32'(aux_drive), p ? 32'h1fff : 32'h0);
      chk({23'h0, power_mgmt_one_bits}, p ? 32'h1ff : 32'h0);
      chk({23'h0, output_control_bits}, p ? 32'h1ff : 32'h0);
      chk(32'(jack_debounce_enable), 32'(p));
    end
    $display("test control done");
    // Unmapped place errors; status ignores writes
    wr(8'h00, 9'h1ff);
    chk(32'(last_err), 32'h1);
    rd(8'h00, 9'h000, 1'b1);
    wr(8'he8, 9'h00f);
    rd(8'he8, 9'h000, 1'b0);
    $display("test unmapped done");
    wrap_up();
  end
endmodule : tb
